//--- design/sfp_defs.vh
// Constants for the store, fence, flush and prefetch block.
// Assumes a single core clock and the request encodings below at the pipeline port.
//
// Operation
// - Non-temporal integer store is weak, never allocates.
// - Misaligned non-temporal single store raises fault.
// - Masked store writes bytes whose mask msb set.
// - Masked stores weakly ordered and never allocate.
// - Store fence: earlier stores visible before later.
// - Load fence: earlier loads visible before later.
// - Full fence orders all earlier loads, stores.
// - Load and store fences ignore each other.
// - Flush invalidates line in all levels, I+D.
// - Flush invalidation broadcast across coherence domain.
// - Dirty flushed line written back before invalidate.
// - Flush covers one 64-byte coherency unit.
// - Flush ignores the page memory type.
// - Flush allowed anywhere, faults like byte load.
// - Flushes unordered; only full fence orders them.
// - Hardware prefetch runs two lines ahead of misses.
// - Hardware prefetch starts after several regular misses.
// - Hardware prefetch may overrun the stream end.
// - Hardware prefetch never crosses a 4K page.
// - Four software prefetch hints, no side effects.
// - Non-temporal stores merge per line, last wins.
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

`define SFP_OP_LOAD   4'h0
`define SFP_OP_STORE  4'h1
`define SFP_OP_NTQ    4'h2
`define SFP_OP_NTPS   4'h3
`define SFP_OP_MASK   4'h4
`define SFP_OP_SFENCE 4'h5
`define SFP_OP_LFENCE 4'h6
`define SFP_OP_MFENCE 4'h7
`define SFP_OP_FLUSH  4'h8
`define SFP_OP_SWPF   4'h9

`define SFP_CMD_LOAD  3'h0
`define SFP_CMD_STORE 3'h1
`define SFP_CMD_WCWR  3'h2
`define SFP_CMD_PROBE 3'h3
`define SFP_CMD_WB    3'h4
`define SFP_CMD_INVAL 3'h5
`define SFP_CMD_PFHW  3'h6
`define SFP_CMD_PFSW  3'h7

`define SFP_LINE_LSB  6
`define SFP_PAGE_LSB  12
`define SFP_LINE_W    26
`define SFP_PF_AHEAD  26'h000_0002
`define SFP_PF_TRIG   2'h2
`define SFP_WC_BEATS  3'h4

`endif

//--- design/sfp_hw_pf.v
// Hardware stream prefetcher fed by first-level data misses.
// Assumes one miss report per cycle at most, as a line number.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defs.vh"
module sfp_hw_pf (
  input  wire                    clk,
  input  wire                    rst_b,
  input  wire                    missValid,
  input  wire [`SFP_LINE_W-1:0]  missLine,
  output reg                     pfValid,
  output reg  [`SFP_LINE_W-1:0]  pfLine
);
  reg  [`SFP_LINE_W-1:0] lastLine_r;
  reg  [1:0]             conf_r;
  wire                   seqHit;
  wire                   samePage;
  wire [`SFP_LINE_W-1:0] target;

  assign seqHit   = missLine == lastLine_r + 26'h000_0001;
  assign samePage = missLine[`SFP_LINE_W-1:6] == lastLine_r[`SFP_LINE_W-1:6];
  assign target   = missLine + `SFP_PF_AHEAD;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lastLine_r <= 26'h000_0000;
      conf_r     <= 2'h0;
      pfValid    <= 1'b0;
      pfLine     <= 26'h000_0000;
    end
    else
    begin
      pfValid <= 1'b0;
      if (missValid)
      begin
        lastLine_r <= missLine;
        if (!samePage)
          conf_r <= 2'h0;
        else if (seqHit && conf_r != 2'h3)
          conf_r <= conf_r + 2'h1;
        else if (!seqHit)
          conf_r <= 2'h0;
        // Keeps going while misses stay sequential and the target stays in the page, even past the stream end.
        if (samePage && seqHit && conf_r >= `SFP_PF_TRIG &&
            target[`SFP_LINE_W-1:6] == missLine[`SFP_LINE_W-1:6])
        begin
          pfValid <= 1'b1;
          pfLine  <= target;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- design/sfp_top.v
// Memory ordering, write combining, line flush and prefetch for the load/store path.
// Assumes the pipeline holds each request until reqAck and the cache keeps command order.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defs.vh"
module sfp_top (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         reqValid,
  input  wire [3:0]   reqOp,
  input  wire [31:0]  reqAddr,
  input  wire [127:0] reqData,
  input  wire [127:0] reqMask,
  input  wire [1:0]   reqHint,
  input  wire         reqPermFault,
  output reg          reqAck,
  output reg          reqFault,
  output reg          cmdValid,
  output reg  [2:0]   cmdCode,
  output reg  [31:0]  cmdAddr,
  output reg  [127:0] cmdData,
  output reg  [15:0]  cmdBe,
  output reg  [1:0]   cmdHint,
  input  wire         cmdReady,
  input  wire         probeDone,
  input  wire         probeDirty,
  input  wire         ackLoad,
  input  wire         ackStore,
  input  wire         missValid,
  input  wire [31:0]  missAddr
);
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_SEND  = 8'h02;
  localparam [7:0] S_DRAIN = 8'h04;
  localparam [7:0] S_DRLD  = 8'h08;
  localparam [7:0] S_FENCE = 8'h10;
  localparam [7:0] S_PROBE = 8'h20;
  localparam [7:0] S_INV   = 8'h40;
  localparam [7:0] S_RESP  = 8'h80;

  reg  [7:0]             state_r;
  reg  [7:0]             ret_r;
  reg  [2:0]             beat_r;
  reg                    wcValid_r;
  reg  [`SFP_LINE_W-1:0] wcLine_r;
  reg                    waitSt_r;
  reg                    waitLd_r;
  reg  [3:0]             loadsPend_r;
  reg  [3:0]             storesPend_r;
  reg                    pfPend_r;
  reg  [`SFP_LINE_W-1:0] pfLine_r;
  wire [15:0]            maskBe;
  wire [15:0]            wrBe;
  wire                   isWcOp;
  wire                   ntpsBad;
  wire                   lineMiss;
  wire                   wcWr;
  wire                   wcClr;
  wire [127:0]           rdData;
  wire [15:0]            rdBe;
  wire                   pfValid;
  wire [`SFP_LINE_W-1:0] pfLine;
  wire                   cmdFire;
  wire                   incLd;
  wire                   incSt;
  wire [31:0]            lineAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode.
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : gMask
      assign maskBe[g] = reqMask[8*g+7];
    end
  endgenerate

  assign isWcOp   = reqOp == `SFP_OP_NTQ || reqOp == `SFP_OP_NTPS ||
                    reqOp == `SFP_OP_MASK;
  assign ntpsBad  = reqOp == `SFP_OP_NTPS && reqAddr[3:0] != 4'h0;
  assign lineMiss = wcValid_r && wcLine_r != reqAddr[31:`SFP_LINE_LSB];
  assign wrBe     = (reqOp == `SFP_OP_MASK) ? maskBe : 16'hFFFF;
  assign wcWr     = state_r == S_IDLE && reqValid && isWcOp && !ntpsBad &&
                    !lineMiss;
  assign wcClr    = state_r == S_DRAIN && beat_r == `SFP_WC_BEATS;
  assign lineAddr = {reqAddr[31:`SFP_LINE_LSB], 6'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Write-combining line and prefetcher.
  sfp_wc_mem uWcMem (
    .clk    (clk),
    .rst_b  (rst_b),
    .wr     (wcWr),
    .wrIdx  (reqAddr[5:4]),
    .wrData (reqData),
    .wrBe   (wrBe),
    .clr    (wcClr),
    .rdIdx  (beat_r[1:0]),
    .rdData (rdData),
    .rdBe   (rdBe)
  );

  sfp_hw_pf uHwPf (
    .clk       (clk),
    .rst_b     (rst_b),
    .missValid (missValid),
    .missLine  (missAddr[31:`SFP_LINE_LSB]),
    .pfValid   (pfValid),
    .pfLine    (pfLine)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outstanding visibility counters.
  assign cmdFire = cmdValid && cmdReady;
  assign incLd   = cmdFire && cmdCode == `SFP_CMD_LOAD;
  assign incSt   = cmdFire && (cmdCode == `SFP_CMD_STORE ||
                   cmdCode == `SFP_CMD_WCWR || cmdCode == `SFP_CMD_WB);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loadsPend_r  <= 4'h0;
      storesPend_r <= 4'h0;
    end
    else
    begin
      case ({incLd, ackLoad})
        2'b10:   loadsPend_r <= loadsPend_r + 4'h1;
        2'b01:   loadsPend_r <= loadsPend_r - 4'h1;
        default: loadsPend_r <= loadsPend_r;
      endcase
      case ({incSt, ackStore})
        2'b10:   storesPend_r <= storesPend_r + 4'h1;
        2'b01:   storesPend_r <= storesPend_r - 4'h1;
        default: storesPend_r <= storesPend_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command loader used by the sequencer.
  task loadCmd;
    input [2:0]   code;
    input [31:0]  addr;
    input [127:0] data;
    input [15:0]  be;
    input [7:0]   ret;
    begin
      cmdValid <= 1'b1;
      cmdCode  <= code;
      cmdAddr  <= addr;
      cmdData  <= data;
      cmdBe    <= be;
      ret_r    <= ret;
      state_r  <= S_SEND;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r   <= S_IDLE;
      ret_r     <= S_IDLE;
      beat_r    <= 3'h0;
      wcValid_r <= 1'b0;
      wcLine_r  <= 26'h000_0000;
      waitSt_r  <= 1'b0;
      waitLd_r  <= 1'b0;
      pfPend_r  <= 1'b0;
      pfLine_r  <= 26'h000_0000;
      reqAck    <= 1'b0;
      reqFault  <= 1'b0;
      cmdValid  <= 1'b0;
      cmdCode   <= 3'h0;
      cmdAddr   <= 32'h0000_0000;
      cmdData   <= 128'h0;
      cmdBe     <= 16'h0000;
      cmdHint   <= 2'h0;
    end
    else
    begin
      reqAck   <= 1'b0;
      reqFault <= 1'b0;
      if (pfValid)
      begin
        pfPend_r <= 1'b1;
        pfLine_r <= pfLine;
      end
      case (state_r)
        S_IDLE:
        begin
          if (reqValid)
          begin
            case (reqOp)
              `SFP_OP_LOAD:
                loadCmd(`SFP_CMD_LOAD, reqAddr, 128'h0, 16'h0000, S_RESP);
              `SFP_OP_STORE:
                loadCmd(`SFP_CMD_STORE, reqAddr, reqData, 16'hFFFF, S_RESP);
              `SFP_OP_NTQ, `SFP_OP_NTPS, `SFP_OP_MASK:
              begin
                if (ntpsBad)
                begin
                  reqAck   <= 1'b1;
                  reqFault <= 1'b1;
                  state_r  <= S_RESP;
                end
                else if (lineMiss)
                begin
                  beat_r  <= 3'h0;
                  state_r <= S_DRAIN;
                end
                else
                begin
                  wcValid_r <= 1'b1;
                  wcLine_r  <= reqAddr[31:`SFP_LINE_LSB];
                  reqAck    <= 1'b1;
                  state_r   <= S_RESP;
                end
              end
              `SFP_OP_SFENCE, `SFP_OP_MFENCE:
              begin
                waitSt_r <= 1'b1;
                waitLd_r <= reqOp == `SFP_OP_MFENCE;
                beat_r   <= 3'h0;
                state_r  <= wcValid_r ? S_DRAIN : S_FENCE;
              end
              `SFP_OP_LFENCE:
              begin
                waitSt_r <= 1'b0;
                waitLd_r <= 1'b1;
                state_r  <= S_FENCE;
              end
              `SFP_OP_FLUSH:
              begin
                if (reqPermFault)
                begin
                  reqAck   <= 1'b1;
                  reqFault <= 1'b1;
                  state_r  <= S_RESP;
                end
                else
                  loadCmd(`SFP_CMD_PROBE, lineAddr, 128'h0, 16'h0000,
                          S_PROBE);
              end
              `SFP_OP_SWPF:
              begin
                cmdHint <= reqHint;
                loadCmd(`SFP_CMD_PFSW, lineAddr, 128'h0, 16'h0000, S_RESP);
              end
              default:
              begin
                reqAck  <= 1'b1;
                state_r <= S_RESP;
              end
            endcase
          end
          else if (pfPend_r && !pfValid)
          begin
            pfPend_r <= 1'b0;
            loadCmd(`SFP_CMD_PFHW, {pfLine_r, 6'h00}, 128'h0, 16'h0000,
                    S_IDLE);
          end
        end
        S_SEND:
        begin
          if (cmdReady)
          begin
            cmdValid <= 1'b0;
            state_r  <= ret_r;
            reqAck   <= ret_r == S_RESP;
          end
        end
        S_DRAIN:
        begin
          if (beat_r == `SFP_WC_BEATS)
          begin
            wcValid_r <= 1'b0;
            state_r   <= (waitSt_r && reqOp != `SFP_OP_NTQ &&
                          reqOp != `SFP_OP_NTPS && reqOp != `SFP_OP_MASK) ?
                         S_FENCE : S_IDLE;
          end
          else
            state_r <= S_DRLD;
        end
        S_DRLD:
        begin
          beat_r <= beat_r + 3'h1;
          loadCmd(`SFP_CMD_WCWR, {wcLine_r, beat_r[1:0], 4'h0}, rdData, rdBe,
                  S_DRAIN);
        end
        S_FENCE:
        begin
          if ((!waitSt_r || storesPend_r == 4'h0) &&
              (!waitLd_r || loadsPend_r == 4'h0))
          begin
            waitSt_r <= 1'b0;
            waitLd_r <= 1'b0;
            reqAck   <= 1'b1;
            state_r  <= S_RESP;
          end
        end
        S_PROBE:
        begin
          if (probeDone)
          begin
            if (probeDirty)
              loadCmd(`SFP_CMD_WB, cmdAddr, 128'h0, 16'h0000, S_INV);
            else
              state_r <= S_INV;
          end
        end
        S_INV:
          loadCmd(`SFP_CMD_INVAL, cmdAddr, 128'h0, 16'h0000,
                  S_RESP);
        S_RESP:
          state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- design/sfp_wc_mem.v
// Write-combining line store: four 16-byte words with byte enables.
// Assumes writes and clears never fall in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module sfp_wc_mem (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         wr,
  input  wire [1:0]   wrIdx,
  input  wire [127:0] wrData,
  input  wire [15:0]  wrBe,
  input  wire         clr,
  input  wire [1:0]   rdIdx,
  output reg  [127:0] rdData,
  output reg  [15:0]  rdBe
);
  reg     [127:0] dataMem [0:3];
  reg     [15:0]  beMem_r [0:3];
  integer         i;
  integer         j;

  ////////////////////////////////////////////////////////////////////////////
  // Later bytes overwrite earlier ones in place.
  always @(posedge clk)
  begin
    for (i = 0; i < 16; i = i + 1)
      if (wr && wrBe[i])
        dataMem[wrIdx][8*i +: 8] <= wrData[8*i +: 8];
    rdData <= dataMem[rdIdx];
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (j = 0; j < 4; j = j + 1)
        beMem_r[j] <= 16'h0000;
      rdBe <= 16'h0000;
    end
    else
    begin
      if (clr)
      begin
        for (j = 0; j < 4; j = j + 1)
          beMem_r[j] <= 16'h0000;
      end
      else if (wr)
        beMem_r[wrIdx] <= beMem_r[wrIdx] | wrBe;
      rdBe <= beMem_r[rdIdx];
    end
  end
endmodule
`default_nettype wire

//--- tb/sfp_mem_model.sv
// Cache and bus model that accepts commands and reports completion.
// Assumes slow is changed only while no command is outstanding.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defs.vh"
module sfp_mem_model (
  input  wire logic       clk,
  input  wire logic       cmdValid,
  input  wire logic [2:0] cmdCode,
  input  wire logic [2:0] slow,
  input  wire logic       dirty,
  output var  logic       cmdReady,
  output var  logic       probeDone,
  output var  logic       probeDirty,
  output var  logic       ackLoad,
  output var  logic       ackStore
);
  logic       take;
  logic [2:0] tCode;
  logic [7:0] ldPipe;
  logic [7:0] stPipe;
  int         waitCnt;
  initial
  begin
    {take, tCode, ldPipe, stPipe, waitCnt} = '0;
    {cmdReady, probeDone, probeDirty, ackLoad, ackStore} = '0;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    take = cmdValid && cmdReady;
    tCode = cmdCode;
  end
  // Ready and acks come slow cycles late; probe result outside its pulse is scrambled.
  always @(negedge clk)
  begin
    ldPipe = {ldPipe[6:0], take && tCode == `SFP_CMD_LOAD};
    stPipe = {stPipe[6:0], take && tCode inside {`SFP_CMD_STORE, `SFP_CMD_WCWR, `SFP_CMD_WB}};
    ackLoad = ldPipe[slow];
    ackStore = stPipe[slow];
    probeDone = take && tCode == `SFP_CMD_PROBE;
    probeDirty = probeDone ? dirty : ~probeDirty;
    waitCnt = (cmdValid && !take) ? waitCnt + 1 : 0;
    cmdReady = cmdValid && waitCnt >= slow;
  end
endmodule
`default_nettype wire

//--- tb/sfp_top_monitor.sv
// Assertion checker for the store, fence, flush and prefetch block.
// Assumes it is bound to sfp_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defs.vh"
module sfp_top_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        reqValid,
  input wire logic [3:0]  reqOp,
  input wire logic [31:0] reqAddr,
  input wire logic        reqAck,
  input wire logic        reqFault,
  input wire logic        cmdValid,
  input wire logic [2:0]  cmdCode,
  input wire logic [31:0] cmdAddr,
  input wire logic        cmdReady,
  input wire logic        probeDone,
  input wire logic        probeDirty,
  input wire logic        ackLoad,
  input wire logic        ackStore,
  input wire logic        missValid,
  input wire logic [31:0] missAddr
);
  logic [3:0]  stCnt_r;
  logic [3:0]  ldCnt_r;
  logic [31:0] lastMiss_r;
  wire         stIss = cmdValid && cmdReady &&
                       cmdCode inside {`SFP_CMD_STORE, `SFP_CMD_WCWR, `SFP_CMD_WB};
  wire         ldIss = cmdValid && cmdReady && cmdCode == `SFP_CMD_LOAD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // Counts stores and loads that are not yet globally visible.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stCnt_r    <= 4'h0;
      ldCnt_r    <= 4'h0;
      lastMiss_r <= 32'h0000_0000;
    end
    else
    begin
      stCnt_r <= stCnt_r + {3'h0, stIss} - {3'h0, ackStore};
      ldCnt_r <= ldCnt_r + {3'h0, ldIss} - {3'h0, ackLoad};
      if (missValid)
        lastMiss_r <= missAddr;
    end
  end
  ////////////////////////////////////////////////////////////////
  fault_needs_ack_a: assert property (reqFault |-> reqAck)
    else $error("fault without ack");
  ntps_fault_a: assert property (
    $rose(reqValid) && reqOp == `SFP_OP_NTPS && reqAddr[3:0] != 4'h0
    |-> ##[1:8] (reqAck && reqFault)) else $error("misaligned store not faulted");
  ntps_ok_a: assert property (
    reqAck && reqOp == `SFP_OP_NTPS && reqAddr[3:0] == 4'h0 |-> !reqFault)
    else $error("aligned store faulted");
  no_alloc_a: assert property (
    reqValid && (reqOp == `SFP_OP_NTQ || reqOp == `SFP_OP_MASK)
    |-> !(cmdValid && cmdCode == `SFP_CMD_STORE)) else $error("streaming store allocated");
  flush_line_a: assert property (
    cmdValid && cmdCode inside {`SFP_CMD_PROBE, `SFP_CMD_WB, `SFP_CMD_INVAL}
    |-> cmdAddr[5:0] == 6'h00) else $error("flush not line aligned");
  wb_first_a: assert property (
    probeDone && probeDirty |-> ##[1:6] (cmdValid && cmdCode == `SFP_CMD_WB))
    else $error("dirty line not written back");
  clean_inval_a: assert property (probeDone && !probeDirty
    |-> ##[1:6] (cmdValid && cmdCode == `SFP_CMD_INVAL)) else $error("clean line not invalidated");
  store_fence_a: assert property (
    reqAck && (reqOp == `SFP_OP_SFENCE || reqOp == `SFP_OP_MFENCE) |-> stCnt_r == 4'h0)
    else $error("fence done with stores pending");
  load_fence_a: assert property (
    reqAck && (reqOp == `SFP_OP_LFENCE || reqOp == `SFP_OP_MFENCE) |-> ldCnt_r == 4'h0)
    else $error("fence done with loads pending");
  pf_ahead_a: assert property (
    cmdValid && cmdCode == `SFP_CMD_PFHW
    |-> cmdAddr[31:6] == lastMiss_r[31:6] + 26'h000_0002 &&
        cmdAddr[31:12] == lastMiss_r[31:12]) else $error("prefetch address wrong");
  cover property (reqAck && reqFault);
  cover property (reqAck && reqOp == `SFP_OP_MFENCE);
  cover property (probeDone && probeDirty);
  cover property (cmdValid && cmdCode == `SFP_CMD_PFHW);
endmodule
`default_nettype wire

//--- tb/sfp_top_tb.sv
// Self-checking testbench for the store, fence, flush and prefetch block.
// Assumes the design files and sfp_defs.vh are on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_defs.vh"
module sfp_top_tb;
  typedef struct packed {logic [2:0] code; logic [31:0] addr; logic [15:0] be;
    logic [127:0] data; logic [1:0] hint;} sfp_cmd_t;
  logic         clk, rst_b, reqValid, reqPermFault, missValid, dirtyIn, f;
  logic [3:0]   reqOp;
  logic [31:0]  reqAddr, missAddr, cmdAddr;
  logic [127:0] reqData, reqMask, cmdData;
  logic [1:0]   reqHint, cmdHint;
  logic [2:0]   slow, cmdCode;
  logic [15:0]  cmdBe;
  logic         reqAck, reqFault, cmdValid, cmdReady, probeDone, probeDirty, ackLoad, ackStore;
  sfp_cmd_t     cq[$];
  int           failCount, checked;
  sfp_top i_sfp_top (.clk, .rst_b, .reqValid, .reqOp, .reqAddr, .reqData, .reqMask, .reqHint,
    .reqPermFault, .reqAck, .reqFault, .cmdValid, .cmdCode, .cmdAddr, .cmdData, .cmdBe, .cmdHint,
    .cmdReady, .probeDone, .probeDirty, .ackLoad, .ackStore, .missValid, .missAddr);
  sfp_mem_model i_sfp_mem_model (.clk, .cmdValid, .cmdCode, .slow, .dirty(dirtyIn), .cmdReady,
    .probeDone, .probeDirty, .ackLoad, .ackStore);
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (cmdValid && cmdReady)
      cq.push_back({cmdCode, cmdAddr, cmdBe, cmdData, cmdHint});
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [3:0] op, input logic [31:0] a, input logic [127:0] d,
                     input logic [127:0] m, input logic [1:0] h);
    int n;
    n = 0;
    @(negedge clk);
    {reqValid, reqOp, reqAddr, reqData, reqMask, reqHint} = {1'b1, op, a, d, m, h};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (reqAck !== 1'b1 && n < 300);
    f = reqFault;
    if (n == 300)
      failCount++;
    @(negedge clk);
    reqValid = 1'b0;
  endtask
  task automatic miss(input logic [31:0] a);
    @(negedge clk);
    {missValid, missAddr} = {1'b1, a};
    @(negedge clk);
    missValid = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic test_wc;
    slow = 3'h3;
    cq.delete();
    req(`SFP_OP_NTQ, 32'h0000_1000, {4{32'h1111_1111}}, '0, 2'h0);
    req(`SFP_OP_NTQ, 32'h0000_1000, {4{32'hAAAA_5555}}, '0, 2'h0);
    req(`SFP_OP_MASK, 32'h0000_1010, {4{32'h7766_5544}}, {4{32'h0080_7F80}}, 2'h0);
    chk(cq.size(), 0);
    req(`SFP_OP_SFENCE, 32'h0000_0000, '0, '0, 2'h0);
    chk(cq.size(), 4);
    for (int i = 0; i < 4; i++)
    begin
      chk(cq[i].code, `SFP_CMD_WCWR);
      chk(cq[i].addr[31:4], 28'h000_0100 + i);
      chk(cq[i].be, i == 0 ? 16'hFFFF : i == 1 ? 16'h5555 : 16'h0000);
    end
    chk(cq[0].data, {4{32'hAAAA_5555}});
    chk({cq[1].data[23:16], cq[1].data[7:0]}, 16'h6644);
    $display("test_wc done");
  endtask
  task automatic test_ntps;
    slow = 3'h1;
    cq.delete();
    req(`SFP_OP_NTPS, 32'h0000_2008, {4{32'h1234_5678}}, '0, 2'h0);
    chk(f, 1'b1);
    req(`SFP_OP_NTPS, 32'h0000_2010, {4{32'h1234_5678}}, '0, 2'h0);
    chk(f, 1'b0);
    req(`SFP_OP_NTQ, 32'h0000_2050, {4{32'h9ABC_DEF0}}, '0, 2'h0);
    chk(cq.size(), 4);
    req(`SFP_OP_MFENCE, 32'h0000_0000, '0, '0, 2'h0);
    chk(cq.size(), 8);
    chk({cq[0].be, cq[1].be}, 32'h0000_FFFF);
    chk({cq[4].addr, cq[5].be}, {32'h0000_2040, 16'hFFFF});
    $display("test_ntps done");
  endtask
  task automatic test_flush;
    slow = 3'h2;
    for (int d = 0; d < 2; d++)
    begin
      cq.delete();
      dirtyIn = d[0];
      req(`SFP_OP_FLUSH, 32'h0000_3025, '0, '0, 2'h0);
      chk(f, 1'b0);
      chk(cq.size(), 2 + d);
      chk({cq[0].code, cq[0].addr}, {`SFP_CMD_PROBE, 32'h0000_3000});
      chk({cq[d].code, cq[d + 1].code}, {d ? `SFP_CMD_WB : `SFP_CMD_PROBE, `SFP_CMD_INVAL});
      chk(cq[d + 1].addr, 32'h0000_3000);
    end
    cq.delete();
    reqPermFault = 1'b1;
    req(`SFP_OP_FLUSH, 32'h0000_3040, '0, '0, 2'h0);
    reqPermFault = 1'b0;
    chk({f, 8'(cq.size())}, 9'h100);
    $display("test_flush done");
  endtask
  task automatic test_fence_pf;
    slow = 3'h5;
    cq.delete();
    req(`SFP_OP_STORE, 32'h0000_4010, {4{32'hCAFE_F00D}}, '0, 2'h0);
    req(`SFP_OP_LOAD, 32'h0000_4000, '0, '0, 2'h0);
    req(`SFP_OP_LFENCE, 32'h0000_0000, '0, '0, 2'h0);
    chk({cq[0].code, cq[0].be}, {`SFP_CMD_STORE, 16'hFFFF});
    chk(cq[1].code, `SFP_CMD_LOAD);
    cq.delete();
    for (int h = 0; h < 4; h++)
    begin
      req(`SFP_OP_SWPF, 32'h0000_4400, '0, '0, h[1:0]);
      chk({cq[h].code, cq[h].hint}, {`SFP_CMD_PFSW, h[1:0]});
    end
    $display("test_fence_pf done");
  endtask
  task automatic test_hwpf;
    slow = 3'h0;
    cq.delete();
    miss(32'h0000_5000);
    miss(32'h0000_5040);
    miss(32'h0000_5080);
    chk(cq.size(), 0);
    miss(32'h0000_50C0);
    chk({cq[0].code, cq[0].addr}, {`SFP_CMD_PFHW, 32'h0000_5140});
    miss(32'h0000_5100);
    chk(cq[1].addr, 32'h0000_5180);
    miss(32'h0000_6F00);
    miss(32'h0000_6F40);
    miss(32'h0000_6F80);
    miss(32'h0000_6FC0);
    chk(cq.size(), 2);
    $display("test_hwpf done");
  endtask
  ////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    print_verdict;
  end
  initial
  begin
    {rst_b, reqValid, reqPermFault, missValid, dirtyIn, f, failCount, checked} = '0;
    {reqOp, reqAddr, missAddr, reqData, reqMask, reqHint, slow} = '0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    test_wc;
    test_ntps;
    test_flush;
    test_fence_pf;
    test_hwpf;
    print_verdict;
  end
endmodule
bind sfp_top sfp_top_monitor i_sfp_top_monitor (.clk, .rst_b, .reqValid, .reqOp, .reqAddr,
  .reqAck, .reqFault, .cmdValid, .cmdCode, .cmdAddr, .cmdReady, .probeDone, .probeDirty,
  .ackLoad, .ackStore, .missValid, .missAddr);
`default_nettype wire
